// ===== core/period_timer_defines.svh
`ifndef PERIOD_TIMER_DEFINES_SVH
`define PERIOD_TIMER_DEFINES_SVH

// register byte addresses
`define PT_ADDR_COUNT 4'h0
`define PT_ADDR_PERIOD 4'h4
`define PT_ADDR_CONTROL 4'h8
`define PT_ADDR_FLAGS 4'hc
`define PT_ADDR_ENABLES 5'h10
`define PT_ADDR_PRIORITY 5'h14
`define PT_ADDR_STATUS 5'h18
`define PT_ADDR_MASK 5'h1c

// control field positions, and the match bit of the flag, enable and priority registers
`define PT_PRE_LSB 0
`define PT_RUN_BIT 2
`define PT_POST_LSB 3
`define PT_MATCH_BIT 1

// reset values
`define PT_PERIOD_RST 8'hff
`define PT_COUNT_RST 8'h00
`define PT_CONTROL_RST 7'h00

// prescale divisors minus one
`define PT_PRE_DIV1 4'h0
`define PT_PRE_DIV4 4'h3
`define PT_PRE_DIV16 4'hf

// instruction tick comes when the divider reaches this, so the system clock is divided by 4
`define PT_INSTR_DIV 2'h3

`endif

// ===== core/period_timer_pkg.sv
package period_timer_pkg;
  typedef struct packed {
    logic [3:0] post_sel;
    logic run;
    logic [1:0] pre_sel;
  } control_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic match;
  } time_base_s;
endpackage

// ===== core/period_timer.sv
// Local design decisions: the AXI4-Lite register port and the address map.
module period_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sync_serial_port_tick,
  output period_timer_pkg::time_base_s pwm_time_base,
  output logic irq_high,
  output logic irq_low,
  output logic irq
);
`include "period_timer_defines.svh"

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [4:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  logic wr_lane0;
  logic rd_go;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_flags;
  logic wr_enables;
  logic wr_priority;
  logic wr_mask;
  logic rd_status;

  // the response waits for both halves, so address and data may arrive in either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_lane0 = wr_go && wstrb_r[0];
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_count = wr_lane0 && awaddr_r == 5'(`PT_ADDR_COUNT);
  assign wr_period = wr_lane0 && awaddr_r == 5'(`PT_ADDR_PERIOD);
  assign wr_control = wr_lane0 && awaddr_r == 5'(`PT_ADDR_CONTROL);
  assign wr_flags = wr_lane0 && awaddr_r == 5'(`PT_ADDR_FLAGS);
  assign wr_enables = wr_lane0 && awaddr_r == `PT_ADDR_ENABLES;
  assign wr_priority = wr_lane0 && awaddr_r == `PT_ADDR_PRIORITY;
  assign wr_mask = wr_lane0 && awaddr_r == `PT_ADDR_MASK;
  assign rd_status = rd_go && s_axi_araddr == `PT_ADDR_STATUS;
  assign s_axi_bresp = 2'h0;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  period_timer_pkg::control_s control_r;
  logic [7:0] period_r;
  logic [7:0] count_r;
  logic flag_r;
  logic enable_r;
  logic priority_r;
  logic status_r;
  logic mask_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      control_r <= `PT_CONTROL_RST;
    end else if (wr_control) begin
      control_r <= wdata_r[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      period_r <= `PT_PERIOD_RST;
    end else if (wr_period) begin
      period_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      enable_r <= 1'b0;
      priority_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      if (wr_enables) begin
        enable_r <= wdata_r[`PT_MATCH_BIT];
      end
      if (wr_priority) begin
        priority_r <= wdata_r[`PT_MATCH_BIT];
      end
      if (wr_mask) begin
        mask_r <= wdata_r[0];
      end
    end
  end

  // ----------------------------------------
  // instruction clock and prescaler
  // ----------------------------------------
  logic [1:0] instr_div_r;
  logic instr_tick;
  logic [3:0] pre_cnt_r;
  logic [3:0] pre_limit;
  logic inc_tick;
  logic scaler_clear;

  assign instr_tick = instr_div_r == `PT_INSTR_DIV;
  assign scaler_clear = wr_count || wr_control;

  always_comb begin
    case (control_r.pre_sel)
      2'h0: pre_limit = `PT_PRE_DIV1;
      2'h1: pre_limit = `PT_PRE_DIV4;
      default: pre_limit = `PT_PRE_DIV16;
    endcase
  end

  // free-running so the instruction phase is not disturbed by register writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      instr_div_r <= 2'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  assign inc_tick = control_r.run && instr_tick && pre_cnt_r == pre_limit;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pre_cnt_r <= 4'h0;
    end else if (scaler_clear) begin
      pre_cnt_r <= 4'h0;
    end else if (control_r.run && instr_tick) begin
      pre_cnt_r <= (pre_cnt_r >= pre_limit) ? 4'h0 : pre_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // timer count and match
  // ----------------------------------------
  logic match_pulse;

  // the match is seen on the increment that reloads zero, so each period gives one pulse
  assign match_pulse = inc_tick && !scaler_clear && count_r == period_r;

  // a count written above the period runs on through ffh and 00h before it matches
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_r <= `PT_COUNT_RST;
    end else if (wr_count) begin
      count_r <= wdata_r[7:0];
    end else if (inc_tick && !wr_control) begin
      count_r <= (count_r == period_r) ? 8'h00 : count_r + 8'h01;
    end
  end

  assign sync_serial_port_tick = match_pulse;
  assign pwm_time_base.count = count_r;
  assign pwm_time_base.period = period_r;
  assign pwm_time_base.match = match_pulse;

  // ----------------------------------------
  // postscaler and flags
  // ----------------------------------------
  logic [3:0] post_cnt_r;
  logic post_hit;

  // only matches advance the postscaler, so a stopped timer never moves it
  assign post_hit = match_pulse && post_cnt_r == control_r.post_sel;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      post_cnt_r <= 4'h0;
    end else if (scaler_clear) begin
      post_cnt_r <= 4'h0;
    end else if (match_pulse) begin
      post_cnt_r <= post_hit ? 4'h0 : post_cnt_r + 4'h1;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else if (post_hit) begin
      flag_r <= 1'b1;
    end else if (wr_flags) begin
      flag_r <= wdata_r[`PT_MATCH_BIT];
    end
  end

  // status feeds the single line and clears on read, so no write is needed to ack it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status_r <= 1'b0;
    end else if (post_hit) begin
      status_r <= 1'b1;
    end else if (rd_status) begin
      status_r <= 1'b0;
    end
  end

  assign irq_high = flag_r && enable_r && priority_r;
  assign irq_low = flag_r && enable_r && !priority_r;
  assign irq = status_r && mask_r;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped reads answer slverr so a wrong address is visible to software
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= 2'h0;
      case (s_axi_araddr)
        5'(`PT_ADDR_COUNT): rdata_r <= {24'h0, count_r};
        5'(`PT_ADDR_PERIOD): rdata_r <= {24'h0, period_r};
        5'(`PT_ADDR_CONTROL): rdata_r <= {25'h0, control_r};
        5'(`PT_ADDR_FLAGS): rdata_r <= {30'h0, flag_r, 1'b0};
        `PT_ADDR_ENABLES: rdata_r <= {30'h0, enable_r, 1'b0};
        `PT_ADDR_PRIORITY: rdata_r <= {30'h0, priority_r, 1'b0};
        `PT_ADDR_STATUS: rdata_r <= {31'h0, status_r};
        `PT_ADDR_MASK: rdata_r <= {31'h0, mask_r};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence run_match_s;
    control_r.run && inc_tick && !scaler_clear && count_r == period_r;
  endsequence

  sequence pre4_quiet_s;
    !inc_tick [*8];
  endsequence

  sequence post_two_s;
    post_hit && control_r.post_sel == 4'h1 && !scaler_clear;
  endsequence

  match_wraps_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    run_match_s |=> count_r == 8'h00) else $error("count did not wrap");
  off_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !control_r.run && !wr_count |=> count_r == $past(count_r))
    else $error("count moved while off");
  off_nomatch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !control_r.run |-> !sync_serial_port_tick) else $error("match while off");
  ctl_keeps_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_control && !wr_count |=> count_r == $past(count_r))
    else $error("control write changed count");
  scaler_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    scaler_clear |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0)
    else $error("scalers not cleared");
  scaler_rst_a: assert property (@(posedge clk_sys)
    !resetn |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0) else $error("scalers not reset");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    post_hit |=> flag_r && status_r) else $error("flag not set");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    flag_r && !wr_flags |=> flag_r) else $error("flag dropped");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_flags && !wdata_r[`PT_MATCH_BIT] && !post_hit |=> !flag_r)
    else $error("flag not cleared");
  status_clr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_status && !post_hit |=> !status_r) else $error("status not cleared by read");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (irq_high || irq_low) |-> flag_r && enable_r) else $error("bad request");
  instr_rate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick) else $error("bad rate");
  pre4_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    inc_tick && control_r.pre_sel == 2'h1 && !$past(scaler_clear) |-> ##1
    pre4_quiet_s) else $error("prescale 4 too fast");
  period_rst_a: assert property (@(posedge clk_sys)
    !resetn |=> period_r == 8'hff) else $error("period reset wrong");
  count_rst_a: assert property (@(posedge clk_sys)
    !resetn |=> count_r == 8'h00) else $error("count reset wrong");
  bit7_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rvalid_r && !$past(rvalid_r) && $past(s_axi_araddr) == 5'h08 |-> !rdata_r[7])
    else $error("bit 7 read nonzero");
  tick_pwm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sync_serial_port_tick |-> pwm_time_base.match && count_r == period_r)
    else $error("tick mismatch");
  pwm_base_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    pwm_time_base.match |-> pwm_time_base.count == pwm_time_base.period ##1
    pwm_time_base.count == 8'h00) else $error("pwm base did not wrap");
  period_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_period |=> period_r == $past(wdata_r[7:0])) else $error("period lost");
  count_wr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_count |=> count_r == $past(wdata_r[7:0])) else $error("count lost");
  post_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    post_two_s |-> ##1
    !post_hit [*3]) else $error("postscale 2 too fast");
endmodule

// ===== bench/pwm_partner.sv
module pwm_partner (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sync_serial_port_tick,
  input wire period_timer_pkg::time_base_s pwm_time_base,
  output logic shift_clk,
  output int tick_total,
  output int last_gap,
  output int bad_base
);
  timeunit 1ns;
  timeprecision 1ps;
  int since;
  // ----------------------------------------
  // serial shift clock and pwm base watcher
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shift_clk <= 1'b0;
      tick_total <= 0;
      last_gap <= 0;
      bad_base <= 0;
      since <= 0;
    end else begin
      since <= since + 1;
      // the pwm match must mirror the serial tick exactly
      if (pwm_time_base.match !== sync_serial_port_tick) begin
        bad_base <= bad_base + 1;
      end
      if (sync_serial_port_tick === 1'b1) begin
        shift_clk <= ~shift_clk;
        tick_total <= tick_total + 1;
        last_gap <= since + 1;
        since <= 0;
        if (pwm_time_base.count !== pwm_time_base.period) begin
          bad_base <= bad_base + 1;
        end
      end
    end
  end
endmodule

// ===== bench/testbench.sv
`include "period_timer_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, resetn = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sync_serial_port_tick, irq_high, irq_low, irq;
  period_timer_pkg::time_base_s pwm_time_base;
  int num_errors = 0, check_count = 0, seed = 99, b, div;
  logic [33:0] exp_q[$];
  logic [7:0] v;
  logic [3:0] codes[4] = '{4'h0, 4'h1, 4'h2, 4'hf};

  period_timer uut (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sync_serial_port_tick(sync_serial_port_tick), .pwm_time_base(pwm_time_base),
    .irq_high(irq_high), .irq_low(irq_low), .irq(irq));
  pwm_partner pm (.clk_sys(clk_sys), .resetn(resetn),
    .sync_serial_port_tick(sync_serial_port_tick), .pwm_time_base(pwm_time_base),
    .shift_clk(), .tick_total(), .last_gap(), .bad_base());

  always #5 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
    @(posedge clk_sys);
    exp_q.push_back({r, 24'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_ticks(input int n);
    b = pm.tick_total;
    repeat (3000) begin
      @(posedge clk_sys);
      if (pm.tick_total >= b + n) break;
    end
  endtask

  // read results are compared in arrival order against the notes of the driver
  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check("bresp", s_axi_bresp, 2'h0);
  end

  initial begin
    #500us;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`PT_ADDR_COUNT, 8'h00);
    rd(`PT_ADDR_PERIOD, 8'hff);
    rd(`PT_ADDR_CONTROL, 8'h00);
    rd(`PT_ADDR_FLAGS, 8'h00);
    rd(`PT_ADDR_ENABLES, 8'h00);
    rd(`PT_ADDR_PRIORITY, 8'h00);
    rd(5'h05, 8'h00, 2'h2);
    v = $random(seed);
    wr(`PT_ADDR_PERIOD, v);
    wr(5'h05, 8'h00); // unaligned, must be ignored
    rd(`PT_ADDR_PERIOD, v);
    v = $random(seed);
    wr(`PT_ADDR_COUNT, v);
    rd(`PT_ADDR_COUNT, v);
    wr(`PT_ADDR_CONTROL, 8'hff);
    rd(`PT_ADDR_CONTROL, 8'h7f);
    // short period keeps the divide-by-16 gap small
    wr(`PT_ADDR_CONTROL, 8'h00);
    wr(`PT_ADDR_COUNT, 8'h00);
    wr(`PT_ADDR_PERIOD, 8'h01);
    for (int c = 0; c < 4; c++) begin
      div = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wr(`PT_ADDR_CONTROL, 8'h04 | 8'(c));
      wait_ticks(3);
      check("gap", pm.last_gap, 8 * div);
    end
    wr(`PT_ADDR_CONTROL, 8'h00);
    rd(`PT_ADDR_STATUS, 8'h01);
    wr(`PT_ADDR_ENABLES, 8'h02);
    wr(`PT_ADDR_MASK, 8'h01);
    foreach (codes[i]) begin
      wr(`PT_ADDR_COUNT, 8'h00);
      wr(`PT_ADDR_FLAGS, 8'h00);
      wr(`PT_ADDR_CONTROL, {1'b0, codes[i], 3'b100});
      b = pm.tick_total;
      repeat (3000) begin
        @(posedge clk_sys);
        if (irq_low === 1'b1) break;
      end
      check("posts", pm.tick_total - b, codes[i] + 1);
      check("irq", irq, 1'b1);
      check("irq_high", irq_high, 1'b0);
      wr(`PT_ADDR_PRIORITY, 8'h02);
      check("irq_high", irq_high, 1'b1);
      check("irq_low", irq_low, 1'b0);
      wr(`PT_ADDR_PRIORITY, 8'h00);
      wr(`PT_ADDR_CONTROL, 8'h00);
      rd(`PT_ADDR_FLAGS, 8'h02);
      wr(`PT_ADDR_FLAGS, 8'h00);
      check("irq_low", irq_low, 1'b0);
      rd(`PT_ADDR_STATUS, 8'h01);
      repeat (2) @(posedge clk_sys);
      check("irq", irq, 1'b0);
    end
    v = $random(seed);
    wr(`PT_ADDR_COUNT, v);
    b = pm.tick_total;
    repeat (100) @(posedge clk_sys);
    rd(`PT_ADDR_COUNT, v);
    check("ticks", pm.tick_total - b, 0);
    wr(`PT_ADDR_CONTROL, 8'h78);
    rd(`PT_ADDR_COUNT, v);
    rd(`PT_ADDR_CONTROL, 8'h78);
    check("pwm_base", pm.bad_base, 0);
    // a second reset in mid-run must restore count and period
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`PT_ADDR_COUNT, 8'h00);
    rd(`PT_ADDR_PERIOD, 8'hff);
    end_of_test();
  end
endmodule
